// ===== src/rspc_top.sv
// Reset, sleep and core power pin sequencing logic.
//
// Overview of operation
// - Power request high, low in sleep
// - Battery fault: sleep or unmaskable exception
// - Ignore wakeups while battery fault asserted
// - Supply fault: sleep or unmaskable exception
// - Ignore supply fault until settling expires
// - Hard reset level sensitive, aborts instruction
// - Start execution at address zero
// - Reset output follows hard reset, delayed release
// - Reset output for soft resets, sleep
// - Read three-bit boot device select
// - Drive tick and oscillator clocks out
module rspc_top
  import rspc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES  = SETTLE_CYC,
  parameter int unsigned RELEASE_CYCLES = RELEASE_CYC,
  parameter int unsigned MAIN_DIV       = 27,
  parameter int unsigned SLOW_DIV       = 3052,
  parameter int unsigned TICK_DIV       = 32768
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  hard_reset_n,
  input  wire rspc_pkg::rspc_ctrl_t  ctrl,
  input  wire logic [2:0]            boot_sel,
  input  wire logic [1:0]            pin_function,
  output rspc_pkg::rspc_stat_t       stat,
  output logic                       clk_pin_out,
  output logic                       clk_pin_oe
);

  import rspc_pkg::*;

  // All sequencer state lives in one record so reset and next-state code stay in step.
  typedef struct packed {
    rspc_state_t           state;
    logic [23:0]           count;
    logic                  settled;
    logic [11:0]           main_div;
    logic [11:0]           slow_div;
    logic                  main_en;
    logic                  slow_en;
    rspc_stat_t            out;
  } rspc_top_st_t;

  rspc_top_st_t st;
  rspc_top_st_t next_st;

  logic batt_fault;
  logic vdd_fault;
  logic soft_reset;
  logic any_fault;
  logic sleep_entry;
  logic wake_allowed;

  assign batt_fault   = ~ctrl.battery_fault_n;
  assign vdd_fault    = ~ctrl.supply_fault_n & st.settled;
  assign soft_reset   = ctrl.watchdog_reset | ctrl.gpio_reset;
  // Either fault pin gets the same response; which one fired is not recorded.
  assign any_fault    = batt_fault | vdd_fault;
  // A fault takes the sleep path only when software chose it over the exception.
  assign sleep_entry  = ctrl.sleep_request | (any_fault & ctrl.fault_to_sleep);
  // Wakeups are refused for as long as the battery fault stands.
  assign wake_allowed = ctrl.wakeup_event & ~batt_fault;

  always_comb begin
    next_st = st;
    next_st.out.abort_instruction = 1'b0;
    next_st.out.fault_exception   = 1'b0;
    // Enables for the oscillator clock outputs, derived from the single core clock.
    // Each enable toggles a level, so a level runs at half the enable rate.
    next_st.main_en = 1'b0;
    next_st.slow_en = 1'b0;
    if (st.main_div == 12'(MAIN_DIV - 1)) begin
      next_st.main_div = 12'h000;
      next_st.main_en  = 1'b1;
    end else begin
      next_st.main_div = st.main_div + 12'h001;
    end
    if (st.slow_div == 12'(SLOW_DIV - 1)) begin
      next_st.slow_div = 12'h000;
      next_st.slow_en  = 1'b1;
    end else begin
      next_st.slow_div = st.slow_div + 12'h001;
    end

    // One down counter serves the release delay and the settling wait, never both at once.
    if (st.count != 24'h000000) begin
      next_st.count = st.count - 24'h000001;
    end
    // Hard reset is looked at before the state, so the pin alone recovers any state.
    if (!hard_reset_n) begin
      next_st.state                  = RSPC_RESET;
      next_st.out.abort_instruction  = (st.state != RSPC_RESET);
      next_st.out.core_reset         = 1'b1;
      next_st.out.system_reset_out_n = 1'b0;
      next_st.out.core_power_request = 1'b1;
      next_st.out.asleep             = 1'b0;
      next_st.settled                = 1'b1;
      next_st.count                  = 24'(RELEASE_CYCLES);
    end else begin
      case (st.state)
        // Release delay: the core stays held until the counter runs out.
        RSPC_RESET: begin
          if (st.count == 24'h000000) begin
            next_st.out.system_reset_out_n = 1'b1;
            next_st.out.core_reset         = 1'b0;
            next_st.out.start_address      = BOOT_ADDR;
            // Boot select is sampled once, at release, so later pin changes do not matter.
            // capture boot select
            next_st.out.boot_device        = boot_sel;
            next_st.state                  = RSPC_RUN;
          end
        end

        // Running: soft resets win over sleep, and sleep wins over the exception.
        RSPC_RUN: begin
          if (soft_reset) begin
            next_st.out.system_reset_out_n = 1'b0;
            next_st.out.core_reset         = 1'b1;
            next_st.count                  = 24'(RELEASE_CYCLES);
            next_st.state                  = RSPC_RESET;
          end else if (sleep_entry) begin
            next_st.out.core_power_request = 1'b0;
            next_st.out.system_reset_out_n = 1'b0;
            next_st.out.core_reset         = 1'b1;
            next_st.out.asleep             = 1'b1;
            next_st.state                  = RSPC_SLEEP;
          end else if (any_fault) begin
            // The exception repeats every cycle the fault stands; nothing here masks it.
            // unmaskable exception
            next_st.out.fault_exception = 1'b1;
          end
        end

        // Asleep: core power is off and only a permitted wakeup or a hard reset leaves.
        RSPC_SLEEP: begin
          if (wake_allowed) begin
            next_st.out.core_power_request = 1'b1;
            next_st.settled                = 1'b0;
            next_st.count                  = 24'(SETTLE_CYCLES);
            next_st.state                  = RSPC_WAKE;
          end
        end

        // Settling: faults are not acted on until the supply timer expires.
        RSPC_WAKE: begin
          if (st.count == 24'h000000) begin
            next_st.settled    = 1'b1;
            next_st.out.asleep = 1'b0;
            next_st.count      = 24'(RELEASE_CYCLES);
            next_st.state      = RSPC_RESET;
          end
        end

        default: begin
          next_st.state = RSPC_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Each field is written once, so the power request is high from the first edge.
      st.state                  <= RSPC_RESET;
      st.count                  <= 24'(RELEASE_CYCLES);
      st.settled                <= 1'b1;
      st.main_div               <= 12'h000;
      st.slow_div               <= 12'h000;
      st.main_en                <= 1'b0;
      st.slow_en                <= 1'b0;
      st.out.core_power_request <= 1'b1;
      st.out.system_reset_out_n <= 1'b0;
      st.out.core_reset         <= 1'b1;
      st.out.abort_instruction  <= 1'b0;
      st.out.fault_exception    <= 1'b0;
      st.out.asleep             <= 1'b0;
      st.out.start_address      <= '0;
      st.out.boot_device        <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from flip-flops; nothing combinational reaches the pins.
  assign stat = st.out;

  rspc_clk_out #(
    .TICK_DIV (TICK_DIV)
  ) u_clk_out (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .main_clk_en  (st.main_en),
    .slow_clk_en  (st.slow_en),
    .pin_function (pin_function),
    .pin_out      (clk_pin_out),
    .pin_oe       (clk_pin_oe)
  );

endmodule : rspc_top

// ===== src/rspc_pkg.sv
// Shared types and constants for the reset, sleep and power pin control block.
package rspc_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  // Fault pulse minimum and supply settling time, in microseconds.
  localparam int unsigned FAULT_MIN_US    = 1000;
  localparam int unsigned SETTLE_US       = 10000;
  localparam int unsigned FAULT_MIN_CYC   = FAULT_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETTLE_CYC      = SETTLE_US * (CLK_HZ / 1_000_000);
  // Cycles between hard reset release and release of the reset output.
  localparam int unsigned RELEASE_CYC     = 16;
  localparam logic [31:0] BOOT_ADDR       = 32'h0000_0000;
  localparam int unsigned BOOT_SEL_W      = 3;

  // Shared pin function selects.
  localparam logic [1:0]  PIN_FN_GPIO     = 2'h0;
  localparam logic [1:0]  PIN_FN_RTC_TICK = 2'h1;
  localparam logic [1:0]  PIN_FN_MAIN_CLK = 2'h2;
  localparam logic [1:0]  PIN_FN_SLOW_CLK = 2'h3;

  typedef enum logic [3:0] {
    RSPC_RESET = 4'b0001,
    RSPC_RUN   = 4'b0010,
    RSPC_SLEEP = 4'b0100,
    RSPC_WAKE  = 4'b1000
  } rspc_state_t;

  typedef struct packed {
    logic battery_fault_n;
    logic supply_fault_n;
    logic wakeup_event;
    logic watchdog_reset;
    logic gpio_reset;
    logic sleep_request;
    logic fault_to_sleep;
  } rspc_ctrl_t;

  typedef struct packed {
    logic        core_power_request;
    logic        system_reset_out_n;
    logic        core_reset;
    logic        abort_instruction;
    logic        fault_exception;
    logic        asleep;
    logic [31:0] start_address;
    logic [BOOT_SEL_W-1:0] boot_device;
  } rspc_stat_t;

endpackage : rspc_pkg

// ===== src/rspc_clk_out.sv
// Shared pin clock output mux with slow clock tick generation.
module rspc_clk_out
  import rspc_pkg::*;
#(
  parameter int unsigned TICK_DIV = 32768
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       main_clk_en,
  input  wire logic       slow_clk_en,
  input  wire logic [1:0] pin_function,
  output logic            pin_out,
  output logic            pin_oe
);

  import rspc_pkg::*;

  typedef struct packed {
    logic [15:0] div;
    logic        rtc_tick;
    logic        main_lvl;
    logic        slow_lvl;
    logic        out;
    logic        oe;
  } rspc_clk_st_t;

  rspc_clk_st_t st;
  rspc_clk_st_t next_st;

  always_comb begin
    next_st = st;
    if (main_clk_en) begin
      next_st.main_lvl = ~st.main_lvl;
    end
    if (slow_clk_en) begin
      next_st.slow_lvl = ~st.slow_lvl;
      // Two enables make one slow clock period, so only the rising half is counted;
      // counting every enable would run the tick at twice its rate.
      if (!st.slow_lvl) begin
        if (st.div == 16'(TICK_DIV - 1)) begin
          next_st.div = 16'h0000;
        end else begin
          next_st.div = st.div + 16'h0001;
        end
      end
      // The tick is high for the first half of each run of TICK_DIV slow periods.
      next_st.rtc_tick = (next_st.div < 16'(TICK_DIV / 2));
    end
    case (pin_function)
      PIN_FN_RTC_TICK: next_st.out = st.rtc_tick;
      PIN_FN_MAIN_CLK: next_st.out = st.main_lvl;
      PIN_FN_SLOW_CLK: next_st.out = st.slow_lvl;
      default:         next_st.out = 1'b0;
    endcase
    next_st.oe = (pin_function != PIN_FN_GPIO);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.out;
  assign pin_oe  = st.oe;

endmodule : rspc_clk_out

// ===== tb/rspc_supply_model.sv
// External supply and reset circuit model that drives the fault and hard reset pins.
module rspc_supply_model #(
  parameter int unsigned HOLD_CYC = 30
) (
  input  wire logic core_clk,
  output logic      hard_reset_n,
  output logic      battery_fault_n,
  output logic      supply_fault_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hard_reset_n    = 1'b1;
    battery_fault_n = 1'b1;
    supply_fault_n  = 1'b1;
  end
  task automatic fault(input bit batt);
    @(negedge core_clk);
    if (batt) battery_fault_n = 1'b0;
    else supply_fault_n = 1'b0;
    repeat (HOLD_CYC) @(negedge core_clk);
    battery_fault_n = 1'b1;
    supply_fault_n  = 1'b1;
  endtask : fault
  task automatic hard_reset();
    @(negedge core_clk);
    hard_reset_n = 1'b0;
    repeat (HOLD_CYC) @(negedge core_clk);
    hard_reset_n = 1'b1;
  endtask : hard_reset
endmodule : rspc_supply_model

// ===== tb/rspc_top_props.sv
// Concurrent checks on the reset, sleep and power pin sequencer ports.
module rspc_top_props
  import rspc_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire logic                 hard_reset_n,
  input wire rspc_pkg::rspc_ctrl_t ctrl,
  input wire logic [2:0]           boot_sel,
  input wire logic [1:0]           pin_function,
  input wire rspc_pkg::rspc_stat_t stat,
  input wire logic                 clk_pin_out,
  input wire logic                 clk_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic ok = stat.system_reset_out_n && hard_reset_n && !ctrl.watchdog_reset
                  && !ctrl.gpio_reset;
  wire logic slp = stat.asleep && !stat.core_power_request && hard_reset_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sleep_power_a: assert property (ok && ctrl.sleep_request
    |=> !stat.core_power_request && stat.asleep) else $error("power kept in sleep");
  wake_power_a: assert property (slp && ctrl.wakeup_event && ctrl.battery_fault_n
    |=> stat.core_power_request) else $error("wake did not power up");
  batt_wake_a: assert property (slp && ctrl.wakeup_event && !ctrl.battery_fault_n
    |=> !stat.core_power_request) else $error("wake taken in battery fault");
  fault_exc_a: assert property (ok && !ctrl.sleep_request && !ctrl.fault_to_sleep
    && !(ctrl.battery_fault_n && ctrl.supply_fault_n) |=> stat.fault_exception)
    else $error("fault raised no exception");
  settle_hold_a: assert property ($rose(stat.core_power_request)
    |=> stat.core_power_request [*8]) else $error("power dropped while settling");
  hard_out_a: assert property (!hard_reset_n |=> !stat.system_reset_out_n)
    else $error("reset out high in hard reset");
  abort_pulse_a: assert property ($fell(hard_reset_n) && stat.system_reset_out_n
    |=> stat.abort_instruction ##1 !stat.abort_instruction) else $error("abort pulse bad");
  sleep_exit_a: assert property (stat.asleep && !stat.core_power_request
    && !hard_reset_n |=> !stat.asleep) else $error("hard reset kept sleep");
  soft_out_a: assert property (stat.system_reset_out_n
    && (ctrl.watchdog_reset || ctrl.gpio_reset) |=> !stat.system_reset_out_n)
    else $error("soft reset ignored");
  sleep_out_a: assert property (stat.asleep |-> !stat.system_reset_out_n)
    else $error("reset out high in sleep");
  pin_enable_a: assert property (1'b1 |=> clk_pin_oe == ($past(pin_function) != PIN_FN_GPIO))
    else $error("pin enable wrong");
  cover property (ok && ctrl.sleep_request);
  cover property (stat.abort_instruction);
  cover property ($rose(stat.system_reset_out_n));
endmodule : rspc_top_props

bind rspc_top rspc_top_props u_props (.core_clk(core_clk), .resetn(resetn),
  .hard_reset_n(hard_reset_n), .ctrl(ctrl), .boot_sel(boot_sel), .pin_function(pin_function),
  .stat(stat), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe));

// ===== tb/rspc_top_tb_top.sv
// Self-checking bench for the reset, sleep and power pin sequencer.
module rspc_top_tb_top;
  import rspc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, resetn, wake, wd, gr, sreq, f2s;
  logic       armed = 1'b0, seen_hi = 1'b0;
  logic [2:0] boot_sel, exp_q[$];
  logic [1:0] pin_fn;
  wire logic  hard_reset_n, batt_n, sup_n;
  rspc_ctrl_t ctrl;
  rspc_stat_t stat;
  logic       pin_out, pin_oe, pin_prev;
  logic [7:0] toggles;
  // Short dividers let each shared pin clock toggle many times in a brief window.
  localparam int unsigned MAIN_SIM = 4, SLOW_SIM = 2, TICK_SIM = 4, WIN = 64;
  localparam logic [7:0] PIN_WANT [4] = '{8'h00, 8'(WIN / (SLOW_SIM * TICK_SIM)),
                                          8'(WIN / MAIN_SIM), 8'(WIN / SLOW_SIM)};
  int         n_errors = 0, compares = 0, cycles = 0;
  assign ctrl = '{batt_n, sup_n, wake, wd, gr, sreq, f2s};
  rspc_supply_model model (.core_clk(core_clk), .hard_reset_n(hard_reset_n),
    .battery_fault_n(batt_n), .supply_fault_n(sup_n));
  rspc_top #(.SETTLE_CYCLES(20), .MAIN_DIV(MAIN_SIM), .SLOW_DIV(SLOW_SIM),
    .TICK_DIV(TICK_SIM)) dut (.core_clk(core_clk), .resetn(resetn),
    .hard_reset_n(hard_reset_n), .ctrl(ctrl), .boot_sel(boot_sel), .pin_function(pin_fn),
    .stat(stat), .clk_pin_out(pin_out), .clk_pin_oe(pin_oe));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [2:0] want);
    compares++;
    if (stat.boot_device !== want || stat.start_address !== BOOT_ADDR) begin
      n_errors++;
      $display("mismatch t=%0t got %h %h want %h 0", $time, stat.boot_device,
               stat.start_address, want);
    end
  endtask : check
  task automatic check_pin(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch t=%0t got %h want %h", $time, got, want);
    end
  endtask : check_pin
  // A new boot selection is noted for every reset that the sequence is about to cause.
  task automatic arm();
    boot_sel = 3'($urandom());
    exp_q.push_back(boot_sel);
  endtask : arm
  task automatic settle();
    for (int i = 0; i < 99 && stat.system_reset_out_n; i++) @(negedge core_clk);
    for (int i = 0; i < 99 && !stat.system_reset_out_n; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask : settle
  always @(negedge core_clk) begin
    if (armed) check(exp_q.pop_front());
    armed = stat.system_reset_out_n === 1'b1 && !seen_hi;
    seen_hi = stat.system_reset_out_n === 1'b1;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'hc5bf));
    {resetn, wake, wd, gr, sreq, f2s, pin_fn} = '0;
    arm();
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    settle();
    for (int i = 0; i < 4; i++) begin
      pin_fn  = i[1:0];
      toggles = 8'h00;
      repeat (2) @(negedge core_clk);
      check_pin(8'(pin_oe), 8'(i != 0));
      pin_prev = pin_out;
      repeat (WIN) begin
        @(negedge core_clk);
        toggles  = toggles + 8'(pin_out != pin_prev);
        pin_prev = pin_out;
      end
      check_pin(toggles, PIN_WANT[i]);
    end
    arm();
    wd = 1'b1;
    @(negedge core_clk);
    wd = 1'b0;
    settle();
    arm();
    gr = 1'b1;
    @(negedge core_clk);
    gr = 1'b0;
    settle();
    sreq = 1'b1;
    @(negedge core_clk);
    sreq = 1'b0;
    fork
      model.fault(1'b1);
      begin
        repeat (10) @(negedge core_clk);
        wake = 1'b1;
        repeat (5) @(negedge core_clk);
        wake = 1'b0;
      end
    join
    arm();
    f2s = 1'b1;
    wake = 1'b1;
    fork
      model.fault(1'b0);
    join_none
    @(negedge core_clk);
    wake = 1'b0;
    settle();
    model.fault(1'b0);
    arm();
    model.hard_reset();
    settle();
    f2s = 1'b0;
    model.fault(1'b1);
    model.fault(1'b0);
    arm();
    model.hard_reset();
    settle();
    conclude();
  end
endmodule : rspc_top_tb_top
